// [rtl/mii_nibble_phy_port.sv]

// Two-entry buffer; ready and valid come straight from flops
module word_buffer #(
	parameter int WIDTH = mii_pkg::ITEM_W
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	logic [WIDTH-1:0] mem_r [0:1];
	logic             wr_ptr_r;
	logic             rd_ptr_r;
	logic [1:0]       cnt_r;
	logic [1:0]       cnt_nxt;
	logic             in_ready_r;
	logic             out_valid_r;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready_r;
	assign pop       = out_valid_r && out_ready;
	assign in_ready  = in_ready_r;
	assign out_valid = out_valid_r;
	assign out_data  = mem_r[rd_ptr_r];

	// Fill level bookkeeping
	always_comb begin
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 2'h1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 2'h1;
		end
	end

	// Flags precomputed so the ports need no gate after the flop
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_r       <= mii_pkg::BUF_EMPTY;
			in_ready_r  <= 1'b1;
			out_valid_r <= 1'b0;
			wr_ptr_r    <= 1'b0;
			rd_ptr_r    <= 1'b0;
		end else begin
			cnt_r       <= cnt_nxt;
			in_ready_r  <= cnt_nxt != mii_pkg::BUF_FULL;
			out_valid_r <= cnt_nxt != mii_pkg::BUF_EMPTY;
			if (push) begin
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop) begin
				rd_ptr_r <= ~rd_ptr_r;
			end
		end
	end

	// Storage
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end
endmodule // word_buffer

module mii_nibble_phy_port (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_byte_last,
	input  wire logic       tx_byte_valid,
	output logic            tx_byte_ready,
	output logic            tx_underrun,
	output logic [7:0]      rx_byte,
	output logic            rx_byte_last,
	output logic            rx_byte_valid,
	input  wire logic       rx_byte_ready,
	output logic            rx_overflow,
	output logic            rx_odd_nibble,
	output logic            rx_frame_active,
	input  wire logic       phy_tx_clock,
	output logic            tx_frame_enable,
	output logic [3:0]      tx_nibble,
	input  wire logic       phy_rx_clock,
	input  wire logic       rx_data_valid,
	input  wire logic [3:0] rx_nibble,
	input  wire logic       collision_in,
	input  wire logic       carrier_sense_in,
	input  wire logic       duplex_select_n,
	output logic            collision,
	output logic            carrier_sense,
	output logic            half_duplex
);
	logic [2:0]                 txc_s_r;
	logic [2:0]                 rxc_s_r;
	logic [1:0]                 dv_s_r;
	logic [3:0]                 rxd_s1_r;
	logic [3:0]                 rxd_s2_r;
	logic [1:0]                 col_s_r;
	logic [1:0]                 crs_s_r;
	logic [1:0]                 dup_s_r;
	logic                       tx_edge;
	logic                       rx_edge;
	mii_pkg::tx_state_e         tx_state_r;
	logic                       tx_en_r;
	logic [3:0]                 tx_nib_r;
	logic [3:0]                 hi_nib_r;
	logic                       last_r;
	logic                       underrun_r;
	logic [mii_pkg::ITEM_W-1:0] txb_data;
	logic                       txb_valid;
	logic                       txb_pop;
	logic                       in_frame_r;
	logic [3:0]                 low_nib_r;
	logic                       have_low_r;
	logic [7:0]                 pend_r;
	logic                       pend_valid_r;
	logic                       overflow_r;
	logic                       odd_r;
	logic                       rxb_push;
	logic [mii_pkg::ITEM_W-1:0] rxb_in;
	logic                       rxb_ready;
	logic [mii_pkg::ITEM_W-1:0] rxb_out;
	logic                       collision_r;
	logic                       carrier_r;
	logic                       half_r;

	// Link clocks and pins are foreign to core_clk: two flops first
	always_ff @(posedge core_clk) begin
		if (reset) begin
			txc_s_r  <= mii_pkg::SYNC_RST;
			rxc_s_r  <= mii_pkg::SYNC_RST;
			dv_s_r   <= 2'h0;
			rxd_s1_r <= mii_pkg::NIB_RST;
			rxd_s2_r <= mii_pkg::NIB_RST;
			col_s_r  <= 2'h0;
			crs_s_r  <= 2'h0;
			dup_s_r  <= 2'h0;
		end else begin
			txc_s_r  <= {txc_s_r[1:0], phy_tx_clock};
			rxc_s_r  <= {rxc_s_r[1:0], phy_rx_clock};
			dv_s_r   <= {dv_s_r[0], rx_data_valid};
			rxd_s1_r <= rx_nibble;
			rxd_s2_r <= rxd_s1_r;
			col_s_r  <= {col_s_r[0], collision_in};
			crs_s_r  <= {crs_s_r[0], carrier_sense_in};
			dup_s_r  <= {dup_s_r[0], duplex_select_n};
		end
	end

	// Edges seen only on the second and third stages
	assign tx_edge = txc_s_r[1] && !txc_s_r[2];
	assign rx_edge = rxc_s_r[1] && !rxc_s_r[2];

	// Holding buffer lets the byte source stall without loss
	word_buffer #(.WIDTH(mii_pkg::ITEM_W)) tx_buf (
		.core_clk  (core_clk),
		.reset     (reset),
		.in_data   ({tx_byte_last, tx_byte}),
		.in_valid  (tx_byte_valid),
		.in_ready  (tx_byte_ready),
		.out_data  (txb_data),
		.out_valid (txb_valid),
		.out_ready (txb_pop)
	);

	// A byte is taken only where the sequencer needs one
	assign txb_pop = tx_edge && ((tx_state_r == mii_pkg::TX_IDLE && !tx_en_r)
		|| tx_state_r == mii_pkg::TX_LOW);

	// Nibble sequencer; a fresh frame waits one idle edge with enable low
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tx_state_r <= mii_pkg::TX_IDLE;
			tx_en_r    <= 1'b0;
			tx_nib_r   <= mii_pkg::NIB_RST;
			hi_nib_r   <= mii_pkg::NIB_RST;
			last_r     <= 1'b0;
			underrun_r <= 1'b0;
		end else begin
			underrun_r <= 1'b0;
			if (tx_edge) begin
				unique case (tx_state_r)
					mii_pkg::TX_IDLE: begin
						if (tx_en_r) begin
							tx_en_r  <= 1'b0;
							tx_nib_r <= mii_pkg::NIB_RST;
						end else if (txb_valid) begin
							tx_en_r    <= 1'b1;
							tx_nib_r   <= txb_data[3:0];
							hi_nib_r   <= txb_data[7:4];
							last_r     <= txb_data[mii_pkg::LAST_BIT];
							tx_state_r <= mii_pkg::TX_HIGH;
						end
					end
					mii_pkg::TX_HIGH: begin
						tx_nib_r   <= hi_nib_r;
						tx_state_r <= last_r ? mii_pkg::TX_IDLE : mii_pkg::TX_LOW;
					end
					mii_pkg::TX_LOW: begin
						if (txb_valid) begin
							tx_nib_r   <= txb_data[3:0];
							hi_nib_r   <= txb_data[7:4];
							last_r     <= txb_data[mii_pkg::LAST_BIT];
							tx_state_r <= mii_pkg::TX_HIGH;
						end else begin
							// Source ran dry mid-frame: the frame is cut short
							tx_en_r    <= 1'b0;
							tx_nib_r   <= mii_pkg::NIB_RST;
							underrun_r <= 1'b1;
							tx_state_r <= mii_pkg::TX_IDLE;
						end
					end
				endcase
			end
		end
	end

	assign tx_frame_enable = tx_en_r;
	assign tx_nibble       = tx_nib_r;
	assign tx_underrun     = underrun_r;

	// A byte is held back one step so its end mark is known on push
	always_comb begin
		rxb_push = 1'b0;
		rxb_in   = {1'b0, pend_r};
		if (rx_edge && pend_valid_r) begin
			if (dv_s_r[1] && have_low_r) begin
				rxb_push = 1'b1;
			end else if (!dv_s_r[1] && in_frame_r) begin
				rxb_push = 1'b1;
				rxb_in   = {1'b1, pend_r};
			end
		end
	end

	// Receive assembly; the PHY cannot be stalled, so a full buffer drops
	always_ff @(posedge core_clk) begin
		if (reset) begin
			in_frame_r   <= 1'b0;
			low_nib_r    <= mii_pkg::NIB_RST;
			have_low_r   <= 1'b0;
			pend_r       <= mii_pkg::BYTE_RST;
			pend_valid_r <= 1'b0;
			overflow_r   <= 1'b0;
			odd_r        <= 1'b0;
		end else begin
			overflow_r <= rxb_push && !rxb_ready;
			odd_r      <= 1'b0;
			if (rx_edge) begin
				if (dv_s_r[1]) begin
					in_frame_r <= 1'b1;
					if (!have_low_r) begin
						low_nib_r  <= rxd_s2_r;
						have_low_r <= 1'b1;
					end else begin
						pend_r       <= {rxd_s2_r, low_nib_r};
						pend_valid_r <= 1'b1;
						have_low_r   <= 1'b0;
					end
				end else begin
					in_frame_r   <= 1'b0;
					have_low_r   <= 1'b0;
					pend_valid_r <= 1'b0;
					odd_r        <= in_frame_r && have_low_r;
				end
			end
		end
	end

	word_buffer #(.WIDTH(mii_pkg::ITEM_W)) rx_buf (
		.core_clk  (core_clk),
		.reset     (reset),
		.in_data   (rxb_in),
		.in_valid  (rxb_push),
		.in_ready  (rxb_ready),
		.out_data  (rxb_out),
		.out_valid (rx_byte_valid),
		.out_ready (rx_byte_ready)
	);

	assign rx_byte         = rxb_out[7:0];
	assign rx_byte_last    = rxb_out[mii_pkg::LAST_BIT];
	assign rx_overflow     = overflow_r;
	assign rx_odd_nibble   = odd_r;
	assign rx_frame_active = in_frame_r;

	// Line status; collision is masked whenever the strap says full duplex
	always_ff @(posedge core_clk) begin
		if (reset) begin
			collision_r <= 1'b0;
			carrier_r   <= 1'b0;
			half_r      <= 1'b0;
		end else begin
			collision_r <= col_s_r[1] && dup_s_r[1];
			carrier_r   <= crs_s_r[1];
			half_r      <= dup_s_r[1];
		end
	end

	assign collision     = collision_r;
	assign carrier_sense = carrier_r;
	assign half_duplex   = half_r;

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	en_rise_a: assert property ($rose(tx_en_r) |->
		$past(tx_edge) && tx_state_r == mii_pkg::TX_HIGH)
		else $error("enable rose without first nibble");
	en_fall_a: assert property ($fell(tx_en_r) |->
		$past(tx_edge) && $past(tx_state_r) != mii_pkg::TX_HIGH)
		else $error("enable fell before last nibble");
	nib_edge_a: assert property ($changed(tx_nib_r) |-> $past(tx_edge))
		else $error("nibble changed off the link edge");
	low_first_a: assert property (txb_pop && txb_valid && !tx_en_r |=>
		tx_en_r && tx_nib_r == $past(txb_data[3:0]))
		else $error("low nibble not sent first");
	rx_take_a: assert property ($changed(pend_r) |-> $past(rx_edge && dv_s_r[1]))
		else $error("byte taken without valid");
	rx_end_a: assert property (rx_edge && !dv_s_r[1] |=> !in_frame_r && !pend_valid_r)
		else $error("frame not ended on low valid");
	col_gate_a: assert property (collision_r |-> half_r)
		else $error("collision seen in full duplex");
	crs_level_a: assert property (carrier_sense_in [*3] |=> carrier_r)
		else $error("carrier not reported");
	dup_strap_a: assert property (!duplex_select_n [*3] |=> !half_r)
		else $error("strap low did not select full duplex");

	tx_frame_c: cover property ($rose(tx_en_r) ##[1:200] $fell(tx_en_r));
	rx_last_c: cover property (rx_byte_valid && rx_byte_last && rx_byte_ready);
	tx_stall_c: cover property (!tx_byte_ready && tx_byte_valid);
	col_c: cover property (collision_r && tx_en_r);
endmodule // mii_nibble_phy_port

// [shared/mii_pkg.sv]
package mii_pkg;
	// Data path widths
	localparam int NIB_W    = 4;
	localparam int BYTE_W   = 8;
	// Buffer items carry a byte plus an end-of-frame mark
	localparam int ITEM_W   = 9;
	localparam int LAST_BIT = 8;
	// Two-entry buffer fill levels
	localparam logic [1:0] BUF_EMPTY = 2'h0;
	localparam logic [1:0] BUF_FULL  = 2'h2;
	// Reset values
	localparam logic [3:0] NIB_RST   = 4'h0;
	localparam logic [7:0] BYTE_RST  = 8'h00;
	localparam logic [2:0] SYNC_RST  = 3'h0;

	// Transmit nibble sequencer
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_LOW  = 2'b01,
		TX_HIGH = 2'b10
	} tx_state_e;
endpackage

// [sim/mii_phy_model.sv]
// Behavioural PHY: free-running link clocks, frame capture and frame send
module mii_phy_model (
	output logic            phy_tx_clock,
	output logic            phy_rx_clock,
	output logic            rx_data_valid,
	output logic [3:0]      rx_nibble,
	input  wire logic       tx_frame_enable,
	input  wire logic [3:0] tx_nibble
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] seen_q[$];
	logic [3:0] low_r  = 4'h0;
	logic       half_r = 1'b0;
	logic       en_r   = 1'b0;

	// Odd offsets keep link edges off the core clock edges
	initial begin
		phy_tx_clock = 1'b0;
		#3;
		forever #100 phy_tx_clock = ~phy_tx_clock;
	end
	initial begin
		phy_rx_clock = 1'b0;
		rx_data_valid = 1'b0;
		rx_nibble = 4'h0;
		#41;
		forever #100 phy_rx_clock = ~phy_rx_clock;
	end

	// Rebuild bytes, low nibble first; end of frame marks the last byte
	always @(posedge phy_tx_clock) begin
		if (tx_frame_enable === 1'b1) begin
			if (half_r)
				seen_q.push_back({1'b0, tx_nibble, low_r});
			else
				low_r = tx_nibble;
			half_r = ~half_r;
		end else if (en_r && seen_q.size() > 0) begin
			seen_q[seen_q.size() - 1][8] = 1'b1;
			half_r = 1'b0;
		end
		en_r = (tx_frame_enable === 1'b1);
	end

	// Data changes on the falling edge; idle data toggles so stale values show
	task automatic send_frame(input logic [7:0] fb[$], input int nibs);
		for (int i = 0; i < nibs; i++) begin
			@(negedge phy_rx_clock);
			rx_data_valid <= 1'b1;
			rx_nibble <= i[0] ? fb[i / 2][7:4] : fb[i / 2][3:0];
		end
		for (int i = 0; i < 3; i++) begin
			@(negedge phy_rx_clock);
			rx_data_valid <= 1'b0;
			rx_nibble <= ~rx_nibble;
		end
	endtask
endmodule // mii_phy_model

// [sim/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       core_clk, reset, tx_byte_last, tx_byte_valid, rx_byte_ready, rx_stall;
	logic       collision_in, carrier_sense_in, duplex_select_n;
	logic [7:0] tx_byte;
	logic       tx_byte_ready, tx_underrun, rx_byte_last, rx_byte_valid, rx_overflow;
	logic       rx_odd_nibble, rx_frame_active, tx_frame_enable, collision, carrier_sense;
	logic       half_duplex, phy_tx_clock, phy_rx_clock, rx_data_valid;
	logic [7:0] rx_byte;
	logic [3:0] tx_nibble, rx_nibble;
	int         err_total, n_checks, seed, ovf_seen, odd_seen, und_seen, act_seen;
	logic       act_prev;
	logic [8:0] exp_tx[$], exp_rx[$], got_rx[$];

	mii_nibble_phy_port mii_nibble_phy_port_i (.core_clk(core_clk), .reset(reset),
		.tx_byte(tx_byte), .tx_byte_last(tx_byte_last), .tx_byte_valid(tx_byte_valid),
		.tx_byte_ready(tx_byte_ready), .tx_underrun(tx_underrun), .rx_byte(rx_byte),
		.rx_byte_last(rx_byte_last), .rx_byte_valid(rx_byte_valid),
		.rx_byte_ready(rx_byte_ready), .rx_overflow(rx_overflow),
		.rx_odd_nibble(rx_odd_nibble), .rx_frame_active(rx_frame_active),
		.phy_tx_clock(phy_tx_clock), .tx_frame_enable(tx_frame_enable),
		.tx_nibble(tx_nibble), .phy_rx_clock(phy_rx_clock),
		.rx_data_valid(rx_data_valid), .rx_nibble(rx_nibble), .collision_in(collision_in),
		.carrier_sense_in(carrier_sense_in), .duplex_select_n(duplex_select_n),
		.collision(collision), .carrier_sense(carrier_sense), .half_duplex(half_duplex));
	mii_phy_model phy_i (.phy_tx_clock(phy_tx_clock), .phy_rx_clock(phy_rx_clock),
		.rx_data_valid(rx_data_valid), .rx_nibble(rx_nibble),
		.tx_frame_enable(tx_frame_enable), .tx_nibble(tx_nibble));

	// Core clock, 40 MHz
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic test_done();
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_q(input string what, input logic [8:0] e[$], input logic [8:0] g[$]);
		check({what, " count"}, 9'(e.size()), 9'(g.size()));
		foreach (e[i])
			if (i < g.size())
				check(what, e[i], g[i]);
	endtask

	// Valid stays up across bytes so no strobe is written twice in one step
	task automatic put_byte(input logic [7:0] b, input logic last);
		tx_byte <= b;
		tx_byte_last <= last;
		tx_byte_valid <= 1'b1;
		@(posedge core_clk);
		while (tx_byte_ready !== 1'b1)
			@(posedge core_clk);
	endtask

	task automatic tx_frame(input int nb);
		logic [7:0] b;
		for (int i = 0; i < nb; i++) begin
			b = 8'($random(seed));
			exp_tx.push_back({i == nb - 1, b});
			put_byte(b, i == nb - 1);
		end
	endtask

	task automatic rx_frame(input int nibs, input int keep);
		logic [7:0] fb[$];
		for (int i = 0; i < (nibs + 1) / 2; i++)
			fb.push_back(8'($random(seed)));
		for (int i = 0; i < nibs / 2 && i < keep; i++)
			exp_rx.push_back({i == nibs / 2 - 1, fb[i]});
		phy_i.send_frame(fb, nibs);
	endtask

	// Random-ready consumer and pulse counters; stall holds ready low
	always @(posedge core_clk) begin
		if (rx_byte_valid === 1'b1 && rx_byte_ready === 1'b1)
			got_rx.push_back({rx_byte_last, rx_byte});
		if (rx_overflow === 1'b1)
			ovf_seen++;
		if (rx_odd_nibble === 1'b1)
			odd_seen++;
		if (tx_underrun === 1'b1)
			und_seen++;
		// Each received frame opens exactly one active window
		if (rx_frame_active === 1'b1 && act_prev !== 1'b1)
			act_seen++;
		act_prev <= rx_frame_active;
		rx_byte_ready <= ~rx_stall & 1'($random(seed));
	end

	// Watchdog well beyond the expected run of at most some 30 us
	initial begin
		#2ms;
		err_total++;
		test_done();
	end

	initial begin
		seed = 96743;
		{reset, tx_byte_last, tx_byte_valid, rx_stall} = 4'h8;
		{collision_in, carrier_sense_in, duplex_select_n, tx_byte} = 11'h000;
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		check("tx_byte_ready", 9'h001, 9'(tx_byte_ready));
		// Back-to-back frames, one-byte frame first, then a cut frame
		for (int f = 0; f < 6; f++)
			tx_frame(f == 0 ? 1 : 1 + {$random(seed)} % 5);
		tx_byte_valid <= 1'b0;
		@(posedge core_clk);
		exp_tx.push_back({1'b1, 8'h5a});
		put_byte(8'h5a, 1'b0);
		tx_byte_valid <= 1'b0;
		for (int i = 0; i < 4000 && !(phy_i.seen_q.size() >= exp_tx.size() && !phy_i.en_r); i++)
			@(posedge core_clk);
		cmp_q("tx frames", exp_tx, phy_i.seen_q);
		check("underrun", 9'h001, 9'(und_seen));
		// Receive: even frames, an odd nibble tail, then overflow under stall
		for (int f = 0; f < 5; f++)
			rx_frame(2 * (1 + {$random(seed)} % 4), 8);
		rx_frame(3, 8);
		rx_stall <= 1'b1;
		rx_frame(10, 2);
		rx_stall <= 1'b0;
		for (int i = 0; i < 4000 && got_rx.size() < exp_rx.size(); i++)
			@(posedge core_clk);
		cmp_q("rx bytes", exp_rx, got_rx);
		check("odd nibble", 9'h001, 9'(odd_seen));
		check("overflow", 9'h003, 9'(ovf_seen));
		check("frame active", 9'h007, 9'(act_seen));
		// Every strap, collision and carrier combination
		for (int i = 0; i < 8; i++) begin
			{duplex_select_n, collision_in, carrier_sense_in} <= 3'(i);
			repeat (5) @(posedge core_clk);
			check("half_duplex", 9'(i[2]), 9'(half_duplex));
			check("collision", 9'(i[2] & i[1]), 9'(collision));
			check("carrier_sense", 9'(i[0]), 9'(carrier_sense));
		end
		test_done();
	end
endmodule // tb
